// ==== rtl/bmdw_pkg.sv ====
/*
  Constants shared by the board memory decode window block: processor and
  system-bus address widths, memory and I/O decode limits, latch layout.
  Assumes a 20-bit processor memory address and 16-bit I/O addresses.
*/
package bmdw_pkg;
  // Address widths
  localparam int CPU_ADDR_W = 20;
  localparam int IO_ADDR_W = 16;
  localparam int SYS_ADDR_W = 24;
  localparam int SEG_BITS = 6;
  localparam int SEG_OFS_BITS = 18;
  localparam int DATA_W = 16;
  // Window latch data field, D7 lands on the top segment bit
  localparam int LATCH_MSB = 7;
  localparam int LATCH_LSB = 2;
  localparam logic [5:0] SEG_RESET = 6'h00;
  // I/O map
  localparam logic [15:0] IO_WINDOW_LATCH = 16'h00D0;
  localparam logic [15:0] IO_ONBOARD_LO = 16'h0080;
  localparam logic [15:0] IO_ONBOARD_HI = 16'h00FF;
  localparam logic [15:0] IO_MOD1_BASE = 16'h0080;
  localparam logic [15:0] IO_MOD2_BASE = 16'h00A0;
  localparam logic [15:0] IO_MOD_SPAN = 16'h0020;
  localparam logic [15:0] IO_MOD_UPPER = 16'h0010;
  // Processor relocation register, kept by software
  localparam logic [15:0] RELOC_OFFSET = 16'hFFFE;
  localparam int RELOC_CASCADE_BIT = 14;
  localparam int RELOC_MEMIO_BIT = 12;
  // Memory map
  localparam logic [19:0] WIN_LO = 20'h80000;
  localparam logic [19:0] WIN_HI = 20'hBFFFF;
  localparam logic [19:0] LOCAL_LO_ABOVE_RAM = 20'h02000;
  localparam logic [19:0] LOCAL_LO_ZERO = 20'h00000;
  localparam logic [19:0] LOCAL_HI_896K = 20'hDFFFF;
  localparam logic [19:0] LOCAL_HI_768K = 20'hBFFFF;
  localparam logic [19:0] LOCAL_HI_512K = 20'h7FFFF;
  // Local range jumper settings
  typedef enum logic [1:0] {
    BMDW_LR_896K,
    BMDW_LR_768K,
    BMDW_LR_512K,
    BMDW_LR_BAD
  } bmdw_lrange_t;
endpackage : bmdw_pkg

// ==== rtl/bmdw_window_latch.sv ====
/*
  Write-only segment window latch: data bits D7 to D2 of an I/O write
  become the high part of the extended system-bus address.
  Assumes the caller qualifies wr_en with the latch port decode.
*/
`timescale 1ns/1ps
module bmdw_window_latch (
  input wire logic clk,
  input wire logic rstn,
  input wire logic wr_en,
  input wire logic [bmdw_pkg::DATA_W-1:0] wr_data,
  output logic [bmdw_pkg::SEG_BITS-1:0] segment
);
  import bmdw_pkg::*;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      segment <= SEG_RESET;
    end else if (wr_en) begin
      segment <= wr_data[LATCH_MSB:LATCH_LSB]; // D7 is top bit
    end
  end
endmodule : bmdw_window_latch

// ==== rtl/bmdw_module_decode.sv ====
/*
  Chip-select decode for one expansion module connector: two selects whose
  addresses depend on the module being 8 or 16 bits wide.
  Assumes io_cycle marks a valid I/O cycle; outputs are combinational.
*/
`timescale 1ns/1ps
module bmdw_module_decode #(
  parameter logic [15:0] BASE = bmdw_pkg::IO_MOD1_BASE
) (
  input wire logic io_cycle,
  input wire logic [bmdw_pkg::IO_ADDR_W-1:0] io_addr,
  input wire logic bhe_n,
  input wire logic wide,
  output logic module_select_zero,
  output logic module_select_one
);
  import bmdw_pkg::*;

  logic [15:0] offset;
  logic in_span;
  logic lower_half;
  logic even_byte;
  logic odd_byte;
  logic word_acc;
  logic lower_even_byte;

  // Window of this connector and access kind
  assign offset = io_addr - BASE;
  assign in_span = io_cycle && (io_addr >= BASE) && (offset < IO_MOD_SPAN);
  assign lower_half = offset < IO_MOD_UPPER;
  assign even_byte = !io_addr[0] && bhe_n;
  assign odd_byte = io_addr[0] && !bhe_n;
  assign word_acc = !io_addr[0] && !bhe_n;
  assign lower_even_byte = in_span && lower_half && even_byte;

  // lower-half even bytes select zero, wide words both
  assign module_select_zero = lower_even_byte || (in_span && lower_half && word_acc && wide);
  assign module_select_one = (in_span && lower_half && word_acc && wide)
                           || (in_span && lower_half && odd_byte && wide)
                           || (in_span && !lower_half && even_byte && !wide);
endmodule : bmdw_module_decode

// ==== rtl/bmdw_decode.sv ====
/*
  Board memory decode window: steers processor memory cycles to the local
  expansion bus or the system bus, extends system addressing through a
  segment window, and decodes the on-board I/O range and module selects.
  Assumes cycle qualifiers come from logic on clk; jumper and strap pins
  are asynchronous. All outputs are registered, one clock behind the processor inputs.
*/
// Functional notes
// - I/O write to 00D0H loads latch
// - Window covers 64 segments of 256KB
// - System address is latch over 18 bits
// - Latch drives lines 23 to 18, D7 top
// - Jumper enables window at 80000H-BFFFFH
// - Default local memory 02000H to 7FFFFH
// - Local starts at zero without low RAM
// - Two jumpers pick local range size
// - Local range over 512KB blocks window
// - Local disabled: system bus, drivers off
// - I/O 0080H-00FFH gives peripheral select one
// - Two module selects per connector
// - First connector lower-half even bytes select zero
`timescale 1ns/1ps
module bmdw_decode #(
  parameter int SYNC_STAGES = 3
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [bmdw_pkg::CPU_ADDR_W-1:0] cpu_addr,
  input wire logic cpu_bhe_n,
  input wire logic cpu_mem_cycle,
  input wire logic cpu_io_cycle,
  input wire logic cpu_io_wr,
  input wire logic [bmdw_pkg::DATA_W-1:0] cpu_wdata,
  input wire logic onboard_mem_hit,
  input wire logic ext16_jumper_pin,
  input wire logic size_first_pin,
  input wire logic size_second_pin,
  input wire logic local_enable_pin,
  input wire logic bank_a_low_pin,
  input wire logic mod1_wide_pin,
  input wire logic mod2_wide_pin,
  output logic sys_mem_sel,
  output logic [bmdw_pkg::SYS_ADDR_W-1:0] sys_addr,
  output logic local_mem_sel,
  output logic local_drv_en,
  output logic peripheral_select_one,
  output logic mod1_select_zero,
  output logic mod1_select_one,
  output logic mod2_select_zero,
  output logic mod2_select_one,
  output logic window_active,
  output logic jumper_fault,
  output logic [bmdw_pkg::SEG_BITS-1:0] segment_window
);
  import bmdw_pkg::*;

  localparam int NUM_STRAPS = 7;

  // Inclusive address band test, shared by the window and local decodes.
  // Both ends count, so a band written as first and last byte is exact;
  // an empty band is a top below its bottom.
  function automatic logic in_band(
    input logic [CPU_ADDR_W-1:0] addr,
    input logic [CPU_ADDR_W-1:0] lo,
    input logic [CPU_ADDR_W-1:0] hi
  );
    in_band = (addr >= lo) && (addr <= hi);
  endfunction : in_band

  // Strap index map
  localparam int S_EXT16 = 0;
  localparam int S_SIZE_A = 1;
  localparam int S_SIZE_B = 2;
  localparam int S_LOCAL_EN = 3;
  localparam int S_BANK_LOW = 4;
  localparam int S_MOD1_WIDE = 5;
  localparam int S_MOD2_WIDE = 6;

  logic [NUM_STRAPS-1:0] strap_pin;
  logic [NUM_STRAPS-1:0] strap;

  // Pins gathered into one vector for the synchroniser loop
  assign strap_pin = {mod2_wide_pin, mod1_wide_pin, bank_a_low_pin, local_enable_pin,
                      size_second_pin, size_first_pin, ext16_jumper_pin};

  // Jumpers are asynchronous: three stages, change taken when the last two
  // agree. Reset reads every jumper as removed until the pins settle.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_STRAPS; gi++) begin : g_strap
      logic [SYNC_STAGES-1:0] stage;
      logic held;
      logic agree;
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          stage <= '0;
        end else begin
          stage <= {stage[SYNC_STAGES-2:0], strap_pin[gi]};
        end
      end
      // Filter looks only at the second and third stages, so a pin that
      // bounces for one sample never reaches the decode
      assign agree = (stage[SYNC_STAGES-1] == stage[SYNC_STAGES-2]);
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          held <= 1'b0;
        end else if (agree) begin
          held <= stage[SYNC_STAGES-1];
        end
      end
      assign strap[gi] = held;
    end
  endgenerate

  // Local range selection from the two size jumpers
  bmdw_lrange_t lrange;
  logic [19:0] local_hi;
  logic [19:0] local_lo;
  logic range_bad;

  always_comb begin
    unique case ({strap[S_SIZE_A], strap[S_SIZE_B]})
      2'h0: lrange = BMDW_LR_896K;
      2'h1: lrange = BMDW_LR_768K;
      2'h2: lrange = BMDW_LR_512K;
      2'h3: lrange = BMDW_LR_BAD;
    endcase
  end

  // Range top per setting; the bad pair maps to an unused top
  always_comb begin
    unique case (lrange)
      BMDW_LR_896K: local_hi = LOCAL_HI_896K;
      BMDW_LR_768K: local_hi = LOCAL_HI_768K;
      BMDW_LR_512K: local_hi = LOCAL_HI_512K;
      BMDW_LR_BAD: local_hi = LOCAL_LO_ZERO;
    endcase
  end

  // Forbidden pair flagged for software and the checker
  assign range_bad = (lrange == BMDW_LR_BAD);

  // zero base when RAM moved away
  assign local_lo = strap[S_BANK_LOW] ? LOCAL_LO_ABOVE_RAM : LOCAL_LO_ZERO;

  // Extended window permission
  logic win_allowed;
  logic in_window;
  logic in_local;
  logic local_en;

  assign win_allowed = strap[S_EXT16] && (lrange == BMDW_LR_512K);

  assign in_window = in_band(cpu_addr, WIN_LO, WIN_HI);

  // A forbidden size pair drops the local bus as well
  // jumpers removed hand range to system
  assign local_en = strap[S_LOCAL_EN] && !range_bad;

  assign in_local = local_en && in_band(cpu_addr, local_lo, local_hi);

  // Memory steering; on-board sockets answer first, local bus next.
  // A forbidden jumper pair disables the local bus rather than guessing.
  logic next_local_sel;
  logic next_sys_sel;
  logic use_window;
  logic [SYS_ADDR_W-1:0] next_sys_addr;
  logic [SYS_ADDR_W-1:0] plain_addr;
  logic [SYS_ADDR_W-1:0] window_addr;

  assign next_local_sel = cpu_mem_cycle && !onboard_mem_hit && in_local;
  assign next_sys_sel = cpu_mem_cycle && !onboard_mem_hit && !in_local;
  assign use_window = win_allowed && in_window;

  // latch lands on lines 23 to 18
  assign window_addr = {segment_window, cpu_addr[SEG_OFS_BITS-1:0]};
  // Outside the window the 20-bit address is zero-extended
  assign plain_addr = {{(SYS_ADDR_W-CPU_ADDR_W){1'b0}}, cpu_addr};
  assign next_sys_addr = use_window ? window_addr : plain_addr;

  // I/O decoding
  logic [IO_ADDR_W-1:0] io_addr;
  logic next_periph_one;
  logic latch_wr;

  // I/O cycles carry a 16-bit port number on the low address lines
  assign io_addr = cpu_addr[IO_ADDR_W-1:0];

  assign next_periph_one = cpu_io_cycle && (io_addr >= IO_ONBOARD_LO)
                           && (io_addr <= IO_ONBOARD_HI);

  // Byte enable ignored: any write to the port loads D7 to D2
  // latch port write strobe
  assign latch_wr = cpu_io_cycle && cpu_io_wr && (io_addr == IO_WINDOW_LATCH);

  bmdw_window_latch u_latch (
    .clk(clk),
    .rstn(rstn),
    .wr_en(latch_wr),
    .wr_data(cpu_wdata),
    .segment(segment_window)
  );

  logic m1_zero;
  logic m1_one;
  logic m2_zero;
  logic m2_one;

  bmdw_module_decode #(
    .BASE(IO_MOD1_BASE)
  ) u_mod1 (
    .io_cycle(cpu_io_cycle),
    .io_addr(io_addr),
    .bhe_n(cpu_bhe_n),
    .wide(strap[S_MOD1_WIDE]),
    .module_select_zero(m1_zero),
    .module_select_one(m1_one)
  );

  bmdw_module_decode #(
    .BASE(IO_MOD2_BASE)
  ) u_mod2 (
    .io_cycle(cpu_io_cycle),
    .io_addr(io_addr),
    .bhe_n(cpu_bhe_n),
    .wide(strap[S_MOD2_WIDE]),
    .module_select_zero(m2_zero),
    .module_select_one(m2_one)
  );

  // Bus selects registered, one clock after the cycle qualifier
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sys_mem_sel <= 1'b0;
      local_mem_sel <= 1'b0;
    end else begin
      sys_mem_sel <= next_sys_sel;
      local_mem_sel <= next_local_sel;
    end
  end

  // System address follows every cycle; it only means something while
  // sys_mem_sel is high, which saves a load enable on 24 flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sys_addr <= '0;
    end else begin
      sys_addr <= next_sys_addr;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      local_drv_en <= 1'b0;
    end else begin
      local_drv_en <= local_en;
    end
  end

  // Jumper status, reported so a bad setting is visible
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      window_active <= 1'b0;
      jumper_fault <= 1'b0;
    end else begin
      window_active <= win_allowed;
      jumper_fault <= range_bad;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      peripheral_select_one <= 1'b0;
    end else begin
      peripheral_select_one <= next_periph_one;
    end
  end

  // Module selects registered alongside the memory steering
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mod1_select_zero <= 1'b0;
      mod1_select_one <= 1'b0;
      mod2_select_zero <= 1'b0;
      mod2_select_one <= 1'b0;
    end else begin
      mod1_select_zero <= m1_zero;
      mod1_select_one <= m1_one;
      mod2_select_zero <= m2_zero;
      mod2_select_one <= m2_one;
    end
  end
endmodule : bmdw_decode

// ==== verification/bmdw_chk.sv ====
/* Port checker for bmdw_decode, bound below.
   Assumes jumpers move only while no memory cycle runs. */
`timescale 1ns/1ps
module bmdw_chk (
  input logic clk,
  input logic rstn,
  input logic [19:0] cpu_addr,
  input logic cpu_bhe_n,
  input logic cpu_mem_cycle,
  input logic cpu_io_cycle,
  input logic cpu_io_wr,
  input logic [15:0] cpu_wdata,
  input logic onboard_mem_hit,
  input logic sys_mem_sel,
  input logic [23:0] sys_addr,
  input logic local_mem_sel,
  input logic local_drv_en,
  input logic peripheral_select_one,
  input logic mod1_select_zero,
  input logic mod1_select_one,
  input logic window_active,
  input logic jumper_fault,
  input logic [5:0] segment_window
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Latch port write and window hit
  wire lw = cpu_io_cycle && cpu_io_wr && cpu_addr[15:0] == 16'h00D0;
  wire wh = cpu_mem_cycle && window_active && !onboard_mem_hit && cpu_addr[19:18] == 2'h2;
  property p_ld; lw |=> segment_window == $past(cpu_wdata[7:2]); endproperty
  a_ld: assert property (p_ld) else $error("latch load");
  property p_hd; !lw |=> $stable(segment_window); endproperty
  a_hd: assert property (p_hd) else $error("latch hold");
  property p_wn; wh |=> sys_mem_sel &&
    sys_addr == {$past(segment_window), $past(cpu_addr[17:0])}; endproperty
  a_wn: assert property (p_wn) else $error("window address");
  property p_fl; cpu_mem_cycle && !window_active |=>
    !sys_mem_sel || sys_addr == {4'h0, $past(cpu_addr)}; endproperty
  a_fl: assert property (p_fl) else $error("flat address");
  property p_ft; jumper_fault |-> !window_active && !local_mem_sel; endproperty
  a_ft: assert property (p_ft) else $error("fault");
  property p_dr; !local_drv_en |-> !local_mem_sel; endproperty
  a_dr: assert property (p_dr) else $error("drivers");
  property p_ps; cpu_io_cycle && cpu_addr[15:7] == 9'h001 |=> peripheral_select_one; endproperty
  a_ps: assert property (p_ps) else $error("peripheral");
  property p_md; cpu_io_cycle && cpu_addr[15:4] == 12'h008 && !cpu_addr[0] && cpu_bhe_n
    |=> mod1_select_zero && !mod1_select_one; endproperty
  a_md: assert property (p_md) else $error("module");
  // Main scenarios reached
  c_ld: cover property (lw);
  c_wn: cover property (wh);
  c_ft: cover property (jumper_fault);
endmodule : bmdw_chk

bind bmdw_decode bmdw_chk bmdw_chk_i (
  .clk(clk),
  .rstn(rstn),
  .cpu_addr(cpu_addr),
  .cpu_bhe_n(cpu_bhe_n),
  .cpu_mem_cycle(cpu_mem_cycle),
  .cpu_io_cycle(cpu_io_cycle),
  .cpu_io_wr(cpu_io_wr),
  .cpu_wdata(cpu_wdata),
  .onboard_mem_hit(onboard_mem_hit),
  .sys_mem_sel(sys_mem_sel),
  .sys_addr(sys_addr),
  .local_mem_sel(local_mem_sel),
  .local_drv_en(local_drv_en),
  .peripheral_select_one(peripheral_select_one),
  .mod1_select_zero(mod1_select_zero),
  .mod1_select_one(mod1_select_one),
  .window_active(window_active),
  .jumper_fault(jumper_fault),
  .segment_window(segment_window)
);

// ==== verification/bmdw_sys_board.sv ====
/* System-bus memory board model: counts cycles it is selected for.
   Assumes registered selects on clk; it never adds waits. */
`timescale 1ns/1ps
module bmdw_sys_board (
  input logic clk,
  input logic rstn,
  input logic sel,
  output int hits
);
  // Cycle counter, cleared by board reset
  // upper select set for zero waits, board answers at once
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hits <= 0;
    end else if (sel) begin
      hits <= hits + 1;
    end
  end
endmodule : bmdw_sys_board

// ==== verification/tb_board_memory_decode_window.sv ====
/* Bench for bmdw_decode against an integer model.
   Assumes the board model file is compiled too. */
`timescale 1ns/1ps
module tb_board_memory_decode_window;
  import bmdw_pkg::*;
  logic clk = 0, rstn = 0, cpu_bhe_n = 1, cpu_mem_cycle = 0, cpu_io_cycle = 0, cpu_io_wr = 0;
  logic onboard_mem_hit = 0, ext16_jumper_pin = 0, size_first_pin = 0, size_second_pin = 0;
  logic local_enable_pin = 0, bank_a_low_pin = 0, mod1_wide_pin = 0, mod2_wide_pin = 0;
  logic [19:0] cpu_addr = 20'h00000;
  logic [15:0] cpu_wdata = 16'h0000;
  logic sys_mem_sel, local_mem_sel, local_drv_en, peripheral_select_one, window_active;
  logic mod1_select_zero, mod1_select_one, mod2_select_zero, mod2_select_one, jumper_fault;
  logic [23:0] sys_addr;
  logic [5:0] segment_window, m_seg = 6'h00;
  logic [19:0] edges [10] = '{20'h00000, 20'h01FFF, 20'h02000, 20'h7FFFF, 20'h80000,
    20'h83FFF, 20'hBFFFF, 20'hC0000, 20'hDFFFF, 20'hE0000};
  int num_errors = 0, n_checks = 0, hits, m_hits = 0;
  // Clock, design and board model
  always #5 clk = ~clk;
  bmdw_decode bmdw_decode_i (
    .clk(clk),
    .rstn(rstn),
    .cpu_addr(cpu_addr),
    .cpu_bhe_n(cpu_bhe_n),
    .cpu_mem_cycle(cpu_mem_cycle),
    .cpu_io_cycle(cpu_io_cycle),
    .cpu_io_wr(cpu_io_wr),
    .cpu_wdata(cpu_wdata),
    .onboard_mem_hit(onboard_mem_hit),
    .ext16_jumper_pin(ext16_jumper_pin),
    .size_first_pin(size_first_pin),
    .size_second_pin(size_second_pin),
    .local_enable_pin(local_enable_pin),
    .bank_a_low_pin(bank_a_low_pin),
    .mod1_wide_pin(mod1_wide_pin),
    .mod2_wide_pin(mod2_wide_pin),
    .sys_mem_sel(sys_mem_sel),
    .sys_addr(sys_addr),
    .local_mem_sel(local_mem_sel),
    .local_drv_en(local_drv_en),
    .peripheral_select_one(peripheral_select_one),
    .mod1_select_zero(mod1_select_zero),
    .mod1_select_one(mod1_select_one),
    .mod2_select_zero(mod2_select_zero),
    .mod2_select_one(mod2_select_one),
    .window_active(window_active),
    .jumper_fault(jumper_fault),
    .segment_window(segment_window)
  );
  bmdw_sys_board bmdw_sys_board_i (.clk(clk), .rstn(rstn), .sel(sys_mem_sel), .hits(hits));
  // Compare one result
  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d, errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic jmp(input logic [4:0] j);
    cpu_mem_cycle = 0;
    cpu_io_cycle = 0;
    {ext16_jumper_pin, size_first_pin, size_second_pin, local_enable_pin, bank_a_low_pin} = j;
    repeat (6) @(negedge clk);
    chk(jumper_fault, j[3] & j[2], "fault");
    chk(window_active, j[4] & j[3] & !j[2], "window");
    chk(local_drv_en, j[1] & !(j[3] & j[2]), "drivers");
  endtask : jmp
  // on-board first, then local range, else system
  task automatic mop(input logic [19:0] a, input logic h);
    logic bad, win, loc;
    logic [19:0] lo, hi;
    cpu_io_cycle = 0;
    cpu_io_wr = 0;
    cpu_mem_cycle = 1;
    cpu_addr = a;
    onboard_mem_hit = h;
    bad = size_first_pin & size_second_pin;
    win = ext16_jumper_pin & size_first_pin & !size_second_pin;
    lo = bank_a_low_pin ? 20'h02000 : 20'h00000;
    hi = size_second_pin ? 20'hBFFFF : (size_first_pin ? 20'h7FFFF : 20'hDFFFF);
    loc = !h & local_enable_pin & !bad & a >= lo & a <= hi;
    @(negedge clk);
    chk(local_mem_sel, loc, "local");
    chk(sys_mem_sel, !h & !loc, "system");
    if (!h & !loc) begin
      m_hits++;
      chk(sys_addr, win & a[19:18] == 2'h2 ? {m_seg, a[17:0]} : {4'h0, a}, "addr");
    end
  endtask : mop
  task automatic wop(input logic [15:0] d);
    cpu_mem_cycle = 0;
    cpu_io_cycle = 1;
    cpu_io_wr = 1;
    cpu_addr = 20'h000D0;
    cpu_wdata = d;
    m_seg = d[7:2];
    @(negedge clk);
    chk(segment_window, m_seg, "segment");
  endtask : wop
  // Module select model, {select one, select zero}
  function automatic logic [1:0] msel(input int a, input int base, input logic b, input logic wd);
    int off;
    off = a - base;
    if (off < 0 || off > 'h1F) return 2'h0;
    if (off < 'h10) return a[0] ? {wd, 1'b0} : {wd & !b, 1'b1};
    return {!a[0] & !wd, 1'b0};
  endfunction : msel
  // I/O read; words only toward a wide module
  task automatic iop(input int a);
    logic wd;
    wd = a < 'hA0 ? mod1_wide_pin : mod2_wide_pin;
    cpu_mem_cycle = 0;
    cpu_io_cycle = 1;
    cpu_io_wr = 0;
    cpu_addr = {4'($urandom), 16'(a)};
    cpu_bhe_n = a[0] ? 1'b0 : (wd ? 1'($urandom) : 1'b1);
    @(negedge clk);
    chk(peripheral_select_one, a >= 'h80 && a <= 'hFF, "pcs");
    chk({mod1_select_one, mod1_select_zero}, msel(a, 'h80, cpu_bhe_n, mod1_wide_pin), "m1");
    chk({mod2_select_one, mod2_select_zero}, msel(a, 'hA0, cpu_bhe_n, mod2_wide_pin), "m2");
    chk(segment_window, m_seg, "held");
  endtask : iop
  // Main sequence
  initial begin
    void'($urandom(42));
    repeat (2) @(negedge clk);
    chk(segment_window, 6'h00, "reset");
    rstn = 1;
    repeat (5) @(negedge clk);
    wop(16'h00A4);
    for (int j = 0; j < 32; j++) begin
      jmp(5'(j));
      foreach (edges[k]) mop(edges[k], 1'b0);
      for (int k = 0; k < 8; k++) mop(20'($urandom), $urandom % 4 == 0);
      wop(16'($urandom));
    end
    chk(hits > 0, 1'b1, "board");
    chk(24'(hits), 24'(m_hits), "board count");
    // Mid-run reset clears the latch
    cpu_io_cycle = 0;
    rstn = 0;
    m_seg = 6'h00;
    @(negedge clk);
    chk(segment_window, 6'h00, "reset again");
    rstn = 1;
    repeat (5) @(negedge clk);
    // Start-up software writes the relocation word; the block ignores it
    cpu_io_cycle = 1;
    cpu_io_wr = 1;
    cpu_addr = {4'h0, RELOC_OFFSET};
    cpu_wdata = 16'h00FF | (16'h0001 << RELOC_CASCADE_BIT);
    @(negedge clk);
    chk(segment_window, m_seg, "relocation write");
    chk(peripheral_select_one, 1'b0, "relocation port");
    chk({mod1_select_one, mod1_select_zero}, 2'h0, "relocation module");
    cpu_io_wr = 0;
    for (int w = 0; w < 2; w++) begin
      mod1_wide_pin = w[0];
      mod2_wide_pin = !w[0];
      repeat (6) @(negedge clk);
      for (int a = 'h70; a < 'h110; a++) iop(a); // ports absolute, base zero
    end
    tally_and_finish;
  end
  // Watchdog, far beyond the expected run
  initial begin
    #100us;
    num_errors++;
    tally_and_finish;
  end
endmodule : tb_board_memory_decode_window
